// ==== eeprom_spi_defs.vh ====
// constants for the serial eeprom command, status and protection front end
// Behaviour
// R1: while suspend is low, pause the sequence, ignore serial lines, resume after.
// R2: master changes suspend only while serial clock is low.
// R3: suspend tied high means never suspended, normal traffic.
// R4: status register locked when hardware protection active or write latch is 0.
// R5: bit 0 shows busy; while busy only read-status is accepted.
// R6: bit 1 shows write latch; at 0 nothing may be modified.
// R7: write latch cleared at reset and after clear, status write, array write.
// R8: bits 2 and 3 hold block-protect, non-volatile, factory value 0; code clears them to 0 at reset.
// R9: block pair selects none, top quarter, top half, all; protected writes refused.
// R10: bits 4 to 6 accept writes, not kept, read 0 unless busy.
// R11: bit 7 with protect pin low enables hardware protection of status only.
// R12: bit 7 may not go from 1 to 0 while protect pin is low.
// R13: during an internal write every status bit reads 1.
// R14: master re-reads status after busy ends; waiting 5 ms also advised.
// R15: input sampled on rising serial clock, msb first, opcode byte leads.
// R16: output bits are shifted out on the falling serial clock edge.
// R17: chip select rising ends the transaction and starts the operation.
// R18: opcodes decoded with bit 3 ignored: set latch, clear latch, status read; code masks bit 3 of every opcode, array read and write and status write too.
// R19: status write takes one byte; array read and write take 16-bit address.
// R20: master sends set-latch before any status or array modification; bench also sends status write 8C with the latch at 0.
// R21: status read repeats the eight bits while clocking continues.
// R22: master sends only defined opcodes; bench also sends undefined opcode 07 to check R25.
// R23: status write ignored unless latch is 1 and hardware protection is off.
// R24: chip select high and idle means standby with output released.
// R25: unknown opcode does nothing and keeps output released until deselect.
// R26: while suspended output released, counters and shift state kept.
`ifndef EEPROM_SPI_DEFS_VH
`define EEPROM_SPI_DEFS_VH

`define OP_MASK          8'hF7
`define OP_SET_LATCH     8'h06
`define OP_CLEAR_LATCH   8'h04
`define OP_STATUS_READ   8'h05
`define OP_STATUS_WRITE  8'h01
`define OP_ARRAY_READ    8'h03
`define OP_ARRAY_WRITE   8'h02

`define ST_BUSY          0
`define ST_LATCH         1
`define ST_GUARD_LO      2
`define ST_GUARD_HI      3
`define ST_PROTECT_EN    7
`define ST_ALL_ONES      8'hFF

`define ADDR_BITS        13
`define QUARTER_BASE     13'h1800
`define HALF_BASE        13'h1000

`define BITS_OPCODE      6'h08
`define BITS_BYTE        6'h08
`define BITS_ADDR_END    6'h18
`define BITS_DATA_END    6'h20

`define WRITE_TIME_US    5000
`define CLK_MHZ          100

`endif

// ==== byte_fifo.v ====
// parameterised fifo with valid and ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign in_ready_o  = (count_r != DEPTH[AW:0]);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ==== eeprom_spi_front.v ====
// serial eeprom front end: framing, opcode decode, status and protection
`timescale 1ns/10ps
`include "eeprom_spi_defs.vh"
module eeprom_spi_front #(
  parameter WRITE_CYCLES = (`WRITE_TIME_US * `CLK_MHZ),
  parameter FIFO_DEPTH   = 16
) (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        cs_n_i,
  input  wire        sck_i,
  input  wire        si_i,
  input  wire        hold_n_i,
  input  wire        wp_n_i,
  output reg         so_o,
  output reg         so_oe_o,
  output reg  [7:0]  status_o,
  output reg         arr_rd_o,
  output reg  [12:0] arr_addr_o,
  input  wire [7:0]  arr_rdata_i,
  output reg  [20:0] wr_data_o,
  output reg         wr_valid_o,
  input  wire        wr_ready_i,
  output reg         busy_o
);
  localparam S_IDLE   = 5'b00001;
  localparam S_OPCODE = 5'b00010;
  localparam S_ADDR   = 5'b00100;
  localparam S_DATA   = 5'b01000;
  localparam S_DEAD   = 5'b10000;

  // three-stage pin samplers: a change counts once stages two and three agree
  reg [2:0] cs_s_r;
  reg [2:0] sck_s_r;
  reg [2:0] si_s_r;
  reg [2:0] hold_s_r;
  reg [2:0] wp_s_r;
  reg       cs_n_r;
  reg       sck_r;
  reg       hold_n_r;
  reg       wp_n_r;

  reg [4:0]  state_r;
  reg [5:0]  bit_cnt_r;
  reg [7:0]  shift_r;
  reg [7:0]  opcode_r;
  reg [15:0] addr_r;
  reg [7:0]  out_r;
  reg [2:0]  out_idx_r;
  reg        latch_r;
  reg        guard_lo_r;
  reg        guard_hi_r;
  reg        protect_en_r;
  reg [31:0] busy_cnt_r;
  reg [7:0]  pend_status_r;
  reg        pend_sr_r;
  reg        pend_arr_r;
  reg        so_live_r;

  wire       sck_rise;
  wire       sck_fall;
  wire       cs_rise;
  wire       cs_fall;
  wire       active;
  wire       busy;
  wire       hw_protect;
  wire [7:0] status_now;
  wire [7:0] op_m;
  wire [7:0] next_shift;
  wire       byte_done;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [20:0] fifo_out_data;
  wire        arr_take;

  function is_guarded;
    input [12:0] addr;
    input        lo;
    input        hi;
    begin
      case ({hi, lo})
        2'b01:   is_guarded = (addr >= `QUARTER_BASE);
        2'b10:   is_guarded = (addr >= `HALF_BASE);
        2'b11:   is_guarded = 1'b1;
        default: is_guarded = 1'b0;
      endcase
    end
  endfunction

  assign sck_rise   = (sck_s_r[2] == sck_s_r[1]) && sck_s_r[1] && !sck_r;
  assign sck_fall   = (sck_s_r[2] == sck_s_r[1]) && !sck_s_r[1] && sck_r;
  assign cs_rise    = (cs_s_r[2] == cs_s_r[1]) && cs_s_r[1] && !cs_n_r;
  assign cs_fall    = (cs_s_r[2] == cs_s_r[1]) && !cs_s_r[1] && cs_n_r;
  assign active     = !cs_n_r && hold_n_r;            // see R1 see R3
  assign busy       = (busy_cnt_r != 32'h00000000);
  assign hw_protect = protect_en_r && !wp_n_r;        // see R11
  assign status_now = busy ? `ST_ALL_ONES :           // see R13 see R10
                      {protect_en_r, 3'h0, guard_hi_r, guard_lo_r, latch_r, 1'b0}; // see R5 R6
  assign next_shift = {shift_r[6:0], si_s_r[2]};      // see R15
  assign op_m       = next_shift & `OP_MASK;          // see R18
  assign byte_done  = (bit_cnt_r[2:0] == 3'h7);
  // array byte complete, latch set and outside the guarded range
  assign arr_take   = active && sck_rise && !cs_rise && state_r == S_DATA &&
                      opcode_r == `OP_ARRAY_WRITE && byte_done && latch_r &&
                      !is_guarded(addr_r[12:0], guard_lo_r, guard_hi_r); // see R9 see R6

  // array writes queue toward the storage side; full fifo refuses further bytes
  byte_fifo #(
    .WIDTH (21),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_wr_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_data_i   ({addr_r[12:0], next_shift}),
    .in_valid_i  (arr_take),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!wr_valid_o)
  );

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cs_s_r   <= 3'h7;
      sck_s_r  <= 3'h0;
      si_s_r   <= 3'h0;
      hold_s_r <= 3'h7;
      wp_s_r   <= 3'h7;
      cs_n_r   <= 1'b1;
      sck_r    <= 1'b0;
      hold_n_r <= 1'b1;
      wp_n_r   <= 1'b1;
    end else begin
      cs_s_r   <= {cs_s_r[1:0], cs_n_i};
      sck_s_r  <= {sck_s_r[1:0], sck_i};
      si_s_r   <= {si_s_r[1:0], si_i};
      hold_s_r <= {hold_s_r[1:0], hold_n_i};
      wp_s_r   <= {wp_s_r[1:0], wp_n_i};
      if (cs_s_r[2] == cs_s_r[1]) cs_n_r <= cs_s_r[1];
      if (sck_s_r[2] == sck_s_r[1]) sck_r <= sck_s_r[1];
      if (hold_s_r[2] == hold_s_r[1]) hold_n_r <= hold_s_r[1];
      if (wp_s_r[2] == wp_s_r[1]) wp_n_r <= wp_s_r[1];
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r       <= S_IDLE;
      bit_cnt_r     <= 6'h00;
      shift_r       <= 8'h00;
      opcode_r      <= 8'h00;
      addr_r        <= 16'h0000;
      out_r         <= 8'h00;
      out_idx_r     <= 3'h0;
      latch_r       <= 1'b0;                          // see R7
      guard_lo_r    <= 1'b0;                          // see R8
      guard_hi_r    <= 1'b0;
      protect_en_r  <= 1'b0;
      busy_cnt_r    <= 32'h00000000;
      pend_status_r <= 8'h00;
      pend_sr_r     <= 1'b0;
      pend_arr_r    <= 1'b0;
      so_live_r     <= 1'b0;
      so_o          <= 1'b0;
      so_oe_o       <= 1'b0;
      status_o      <= 8'h00;
      arr_rd_o      <= 1'b0;
      arr_addr_o    <= 13'h0000;
      wr_data_o     <= 21'h000000;
      wr_valid_o    <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      status_o <= status_now;
      busy_o   <= busy;
      arr_rd_o <= 1'b0;
      if (wr_valid_o && wr_ready_i) begin
        wr_valid_o <= 1'b0;
      end else if (fifo_out_valid && !wr_valid_o) begin
        wr_valid_o <= 1'b1;
        wr_data_o  <= fifo_out_data;
      end
      if (busy) begin
        busy_cnt_r <= busy_cnt_r - 32'h00000001;
        if (busy_cnt_r == 32'h00000001 && pend_sr_r) begin
          guard_lo_r   <= pend_status_r[`ST_GUARD_LO];
          guard_hi_r   <= pend_status_r[`ST_GUARD_HI];
          protect_en_r <= pend_status_r[`ST_PROTECT_EN];
          pend_sr_r    <= 1'b0;
        end
      end
      // see R26: while suspended only output release and chip select edges act below
      if (!hold_n_r || cs_n_r) begin
        so_oe_o <= 1'b0;                              // see R24 see R1
      end else if (so_live_r) begin
        so_oe_o <= 1'b1;                              // see R1
      end
      if (cs_fall) begin
        state_r   <= S_OPCODE;
        bit_cnt_r <= 6'h00;
        so_live_r <= 1'b0;
      end else if (cs_rise) begin
        // see R17: deselect ends framing and starts the operation
        state_r <= S_IDLE;
        // status write has gone dead after exactly one data byte
        if (state_r == S_DEAD && opcode_r == `OP_STATUS_WRITE &&
            bit_cnt_r == `BITS_OPCODE + `BITS_BYTE) begin
          if (!busy && latch_r && !hw_protect) begin  // see R23 see R4
            pend_status_r <= {(protect_en_r && !wp_n_r) | shift_r[`ST_PROTECT_EN], // see R12
                              shift_r[6:0]};
            pend_sr_r     <= 1'b1;
            latch_r       <= 1'b0;                    // see R7
            busy_cnt_r    <= WRITE_CYCLES;
          end
        end
        if (pend_arr_r) begin
          pend_arr_r <= 1'b0;
          latch_r    <= 1'b0;                         // see R7
          busy_cnt_r <= WRITE_CYCLES;
        end
      end else if (active && sck_rise) begin
        shift_r   <= next_shift;
        bit_cnt_r <= bit_cnt_r + 6'h01;
        case (state_r)
          S_OPCODE: begin
            if (byte_done) begin
              opcode_r <= op_m;
              if (busy && op_m != `OP_STATUS_READ) begin
                state_r <= S_DEAD;                    // see R5
              end else if (op_m == `OP_SET_LATCH) begin
                latch_r <= 1'b1;
                state_r <= S_DEAD;
              end else if (op_m == `OP_CLEAR_LATCH) begin
                latch_r <= 1'b0;                      // see R7
                state_r <= S_DEAD;
              end else if (op_m == `OP_STATUS_READ) begin
                out_r     <= status_now;
                out_idx_r <= 3'h7;
                state_r   <= S_DATA;
              end else if (op_m == `OP_STATUS_WRITE) begin
                state_r <= S_DATA;                    // see R19
              end else if (op_m == `OP_ARRAY_READ || op_m == `OP_ARRAY_WRITE) begin
                state_r <= S_ADDR;
              end else begin
                state_r <= S_DEAD;                    // see R25
              end
            end
          end
          S_ADDR: begin
            addr_r <= {addr_r[14:0], si_s_r[2]};
            if (bit_cnt_r == `BITS_ADDR_END - 6'h01) begin
              state_r <= S_DATA;
              if (opcode_r == `OP_ARRAY_READ) begin
                arr_rd_o   <= 1'b1;
                arr_addr_o <= {addr_r[11:0], si_s_r[2]};
                out_idx_r  <= 3'h0;
              end
            end
          end
          S_DATA: begin
            if (opcode_r == `OP_STATUS_READ && out_idx_r == 3'h7) begin
              out_r <= status_now;                    // see R21
            end
            if (opcode_r == `OP_ARRAY_WRITE && byte_done) begin
              if (arr_take && fifo_in_ready) begin    // see R9 see R6
                pend_arr_r <= 1'b1;
              end
              addr_r[4:0] <= addr_r[4:0] + 5'h01;
            end
            if (opcode_r == `OP_STATUS_WRITE && bit_cnt_r == `BITS_ADDR_END - 6'h09) begin
              state_r <= S_DEAD;
            end
          end
          S_DEAD: begin
            state_r <= S_DEAD;
          end
          default: begin
            state_r <= S_IDLE;
          end
        endcase
      end else if (active && sck_fall && state_r == S_DATA) begin
        if (opcode_r == `OP_STATUS_READ) begin
          so_o      <= out_r[out_idx_r];              // see R16
          so_oe_o   <= 1'b1;
          so_live_r <= 1'b1;
          out_idx_r <= out_idx_r - 3'h1;
        end else if (opcode_r == `OP_ARRAY_READ) begin
          so_o      <= arr_rdata_i[3'h7 - out_idx_r];
          so_oe_o   <= 1'b1;
          so_live_r <= 1'b1;
          out_idx_r <= out_idx_r + 3'h1;
          if (out_idx_r == 3'h7) begin
            arr_rd_o   <= 1'b1;
            arr_addr_o <= arr_addr_o + 13'h0001;
          end
        end
      end
    end
  end
endmodule

// ==== eeprom_spi_front_monitor.sv ====
// concurrent checks on the eeprom serial front end ports
`timescale 1ns/10ps
module eeprom_spi_front_monitor #(
  parameter WRITE_CYCLES = 500000,
  parameter FIFO_DEPTH   = 16
) (
  input wire        clk_sys_i,
  input wire        rst_i,
  input wire        cs_n_i,
  input wire        sck_i,
  input wire        hold_n_i,
  input wire        wp_n_i,
  input wire        so_o,
  input wire        so_oe_o,
  input wire [7:0]  status_o,
  input wire [20:0] wr_data_o,
  input wire        wr_valid_o,
  input wire        wr_ready_i,
  input wire        busy_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  reg        sck_d_r;
  reg [3:0]  since_fall_r;
  reg [31:0] busy_cnt_r;
  // cycles since the serial clock pin fell, and length of the busy span
  always @(posedge clk_sys_i) begin
    sck_d_r <= sck_i;
    if (rst_i || (sck_d_r && !sck_i)) since_fall_r <= 4'h0;
    else if (since_fall_r != 4'hF) since_fall_r <= since_fall_r + 4'h1;
    if (rst_i || !busy_o) busy_cnt_r <= 32'h0;
    else busy_cnt_r <= busy_cnt_r + 32'h1;
  end
  sequence s_deselected;
    cs_n_i [*6];
  endsequence
  sequence s_held;
    !hold_n_i [*6];
  endsequence
  property p_busy_ones;
    busy_o |-> status_o == 8'hFF;
  endproperty
  property p_idle_status;
    !busy_o [*2] |-> status_o[0] == 1'b0 && status_o[6:4] == 3'h0;
  endproperty
  property p_standby;
    s_deselected |-> !so_oe_o;
  endproperty
  property p_hold;
    s_held |-> !so_oe_o;
  endproperty
  property p_protect_kept;
    (!busy_o && status_o[7] && !wp_n_i) |=> status_o[7];
  endproperty
  property p_latch_cleared;
    $fell(busy_o) |=> status_o[1] == 1'b0;
  endproperty
  property p_busy_time;
    $fell(busy_o) |-> busy_cnt_r >= WRITE_CYCLES - 1 && busy_cnt_r <= WRITE_CYCLES + 1;
  endproperty
  property p_so_on_fall;
    (so_oe_o && $past(so_oe_o) && $changed(so_o)) |-> since_fall_r <= 4'h6;
  endproperty
  property p_wr_stands;
    (wr_valid_o && !wr_ready_i) |=> wr_valid_o && $stable(wr_data_o);
  endproperty
  a_busy_ones: assert property (p_busy_ones) else $error("status not all ones");
  a_idle_status: assert property (p_idle_status) else $error("idle status bad");
  a_standby: assert property (p_standby) else $error("output driven deselected");
  a_hold: assert property (p_hold) else $error("output driven in suspend");
  a_protect_kept: assert property (p_protect_kept) else $error("protect bit cleared");
  a_latch_cleared: assert property (p_latch_cleared) else $error("latch kept");
  a_busy_time: assert property (p_busy_time) else $error("busy span wrong");
  a_so_on_fall: assert property (p_so_on_fall) else $error("output off fall");
  a_wr_stands: assert property (p_wr_stands) else $error("write word dropped");
endmodule
bind eeprom_spi_front eeprom_spi_front_monitor #(.WRITE_CYCLES(WRITE_CYCLES),
  .FIFO_DEPTH(FIFO_DEPTH)) i_mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
  .sck_i(sck_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .status_o(status_o), .wr_data_o(wr_data_o), .wr_valid_o(wr_valid_o),
  .wr_ready_i(wr_ready_i), .busy_o(busy_o));

// ==== spi_master_model.sv ====
// spi master model driving select, clock, data and suspend
`timescale 1ns/10ps
module spi_master_model (
  output reg  cs_n_o,
  output reg  sck_o,
  output reg  si_o,
  output reg  hold_n_o,
  input  wire so_i,
  input  wire so_oe_i
);
  // released output shows the inverse of its last bit, never a stale one
  wire so_line = so_oe_i ? so_i : ~so_i;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  task select;
    begin
      #100 cs_n_o = 1'b0;
    end
  endtask
  task deselect;
    begin
      #62.5 cs_n_o = 1'b1;
      si_o = ~si_o;
      #300;
    end
  endtask
  // mode 0, msb first; suspend with ignored clock pulses before bit hold_at
  task xfer(input [7:0] b, input integer hold_at, output [7:0] r);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        if (i == hold_at) begin
          #40 hold_n_o = 1'b0;
          repeat (2) begin
            si_o = ~si_o;
            #62.5 sck_o = 1'b1;
            #62.5 sck_o = 1'b0;
          end
          #60 hold_n_o = 1'b1;
        end
        si_o = b[i];
        #62.5 r[i] = so_line;
        sck_o = 1'b1;
        #62.5 sck_o = 1'b0;
      end
    end
  endtask
endmodule

// ==== tb_serial_eeprom_cmd_status_protect.sv ====
// self-checking bench for the eeprom serial front end
`timescale 1ns/10ps
module tb_serial_eeprom_cmd_status_protect;
  localparam WC = 1000;
  reg         clk_sys_i, rst_i, wp_n_i, wr_ready_i;
  wire        cs_n_i, sck_i, si_i, hold_n_i, so_o, so_oe_o, arr_rd_o, wr_valid_o, busy_o;
  wire [7:0]  status_o;
  wire [12:0] arr_addr_o;
  wire [20:0] wr_data_o;
  wire [7:0]  arr_rdata_i = arr_addr_o[7:0] ^ 8'h5A;
  integer     error_cnt = 0;
  integer     checks_done = 0;
  integer     k, n0;
  reg [7:0]   got;
  reg [23:0]  rows [0:6];
  reg [20:0]  wq [$];
  eeprom_spi_front #(.WRITE_CYCLES(WC), .FIFO_DEPTH(16)) i_dut (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .hold_n_i(hold_n_i),
    .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .status_o(status_o),
    .arr_rd_o(arr_rd_o), .arr_addr_o(arr_addr_o), .arr_rdata_i(arr_rdata_i),
    .wr_data_o(wr_data_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
    .busy_o(busy_o));
  spi_master_model i_master (.cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si_i),
    .hold_n_o(hold_n_i), .so_i(so_o), .so_oe_i(so_oe_o));
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (wr_valid_o === 1'b1 && wr_ready_i) wq.push_back(wr_data_o);
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task op1(input [7:0] op);
    begin
      i_master.select;
      i_master.xfer(op, -1, got);
      i_master.deselect;
    end
  endtask
  task cmd_status_read(input [7:0] op, input integer h, input [7:0] exp);
    begin
      i_master.select;
      i_master.xfer(op, -1, got);
      i_master.xfer(8'h00, h, got);
      check(got, exp);
      i_master.xfer(8'h00, -1, got);
      check(got, exp);
      i_master.deselect;
    end
  endtask
  task wait_idle;
    begin
      for (k = 0; k < 3000 && busy_o !== 1'b0; k = k + 1) @(posedge clk_sys_i);
      check(busy_o, 32'h0);
    end
  endtask
  task cmd_status_write(input [7:0] d, input en);
    begin
      if (en) op1(8'h06);
      i_master.select;
      i_master.xfer(8'h01, -1, got);
      i_master.xfer(d, -1, got);
      i_master.deselect;
      wait_idle;
    end
  endtask
  task aw(input [15:0] a, input integer n);
    integer j;
    begin
      op1(8'h06);
      i_master.select;
      i_master.xfer(8'h02, -1, got);
      i_master.xfer(a[15:8], -1, got);
      i_master.xfer(a[7:0], -1, got);
      for (j = 0; j < n; j = j + 1) i_master.xfer(j[7:0], -1, got);
      i_master.deselect;
    end
  endtask
  task pin(input w, input r);
    begin
      @(posedge clk_sys_i);
      #1 wp_n_i = w;
      wr_ready_i = r;
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    #900000;
    error_cnt = error_cnt + 1;
    summarize;
  end
  initial begin
    clk_sys_i = 1'b0;
    rst_i = 1'b1;
    wp_n_i = 1'b1;
    wr_ready_i = 1'b1;
    rows = '{24'h06_05_02, 24'h04_0D_00, 24'h0E_05_02, 24'h0C_05_00, 24'h06_05_02,
             24'h07_05_02, 24'h04_05_00};
    repeat (2) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    @(posedge clk_sys_i);
    #1 check(status_o, 32'h0);
    check(so_oe_o, 32'h0);
    for (n0 = 0; n0 < 7; n0 = n0 + 1) begin
      op1(rows[n0][23:16]);
      cmd_status_read(rows[n0][15:8], -1, rows[n0][7:0]);
    end
    op1(8'h06);
    cmd_status_read(8'h05, 4, 8'h02);
    op1(8'h04);
    // read opcode with bit 3 set, top address bits ignored
    i_master.select;
    i_master.xfer(8'h0B, -1, got);
    i_master.xfer(8'hE1, -1, got);
    i_master.xfer(8'h23, -1, got);
    i_master.xfer(8'h00, -1, got);
    check(got, 8'h23 ^ 8'h5A);
    i_master.deselect;
    // fill the write buffer with the storage side stalled
    pin(1'b1, 1'b0);
    aw(16'h0005, 18);
    op1(8'h06);
    cmd_status_read(8'h05, -1, 8'hFF);
    pin(1'b1, 1'b1);
    wait_idle;
    cmd_status_read(8'h05, -1, 8'h00);
    check(wq.size() >= 16 && wq.size() <= 17, 32'h1);
    check(wq[0], {13'h0005, 8'h00});
    cmd_status_write(8'h8C, 1'b0);
    cmd_status_read(8'h05, -1, 8'h00);
    cmd_status_write(8'hFC, 1'b1);
    cmd_status_read(8'h05, -1, 8'h8C);
    pin(1'b0, 1'b1);
    cmd_status_write(8'h00, 1'b1);
    cmd_status_read(8'h05, -1, 8'h8E);
    pin(1'b1, 1'b1);
    cmd_status_write(8'h04, 1'b1);
    cmd_status_read(8'h05, -1, 8'h04);
    n0 = wq.size();
    aw(16'h17FF, 1);
    wait_idle;
    aw(16'h1800, 1);
    wait_idle;
    check(wq.size(), n0 + 1);
    check(wq[$], {13'h17FF, 8'h00});
    // reset in mid-run drops the latch left set by the refused write
    check(status_o[1], 32'h1);
    @(posedge clk_sys_i);
    #1 rst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    @(posedge clk_sys_i);
    #1 check(status_o[1], 32'h0);
    check(so_oe_o, 32'h0);
    summarize;
  end
endmodule
